// ### pkg/osc_defines.svh
// timing counts and encodings for the oversampling conversion control
`ifndef OSC_DEFINES_SVH
`define OSC_DEFINES_SVH
`define OSC_NUM_CH          8
`define OSC_DATA_W          14
`define OSC_SEL_W           3
`define OSC_SEL_RESET       3'h0
`define OSC_CONV_NS         1000
`define OSC_CLK_NS          50
`define OSC_CONV_CYCLES     ((`OSC_CONV_NS + `OSC_CLK_NS - 1) / `OSC_CLK_NS)
`define OSC_SEL_MAX_RATIO   3'h6
`endif

// ### pkg/osc_pkg.sv
// types for the oversampling conversion control
package osc_pkg;
    typedef enum logic [1:0] {
        OSC_IDLE,
        OSC_REQ,
        OSC_WAIT,
        OSC_DONE
    } osc_state_t;
endpackage : osc_pkg

// ### rtl/osc_avg.sv
// per-channel accumulator that averages a power-of-two number of samples
`timescale 1ns/1ps
module osc_avg #(
    parameter int DATA_W = 14,
    parameter int SEL_W  = 3
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // control
    input  wire logic              clear,
    input  wire logic              add,
    input  wire logic [SEL_W-1:0]  shift,
    // sample and result
    input  wire logic signed [DATA_W-1:0] sample,
    output logic signed [DATA_W-1:0]      mean
);
    localparam int ACC_W = DATA_W + 7;
    logic signed [ACC_W-1:0] acc;
    logic signed [ACC_W-1:0] next_acc;
    logic signed [ACC_W-1:0] sum;

    // accumulate samples, mean is the sum shifted by log2 ratio
    always_comb begin
        sum      = acc + ACC_W'(sample);
        next_acc = acc;
        if (clear) begin
            next_acc = '0;
        end else if (add) begin
            next_acc = sum;
        end
        mean = DATA_W'(acc >>> shift);
    end

    // accumulator register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            acc <= '0;
        end else begin
            acc <= next_acc;
        end
    end
endmodule : osc_avg

// ### rtl/osc_ctrl.sv
// conversion sequencing with oversampling and averaging filter
// Functional notes
// - ratio select pins latched when busy falls, used by the next conversion.
// - busy high time grows with the selected oversampling ratio.
// - reads during busy return the previously completed results.
// - output data registers load new results as busy falls.
// - in oversampling modes results pass through the averaging filter.
`timescale 1ns/1ps
`include "osc_defines.svh"
module osc_ctrl #(
    parameter int NUM_CH      = `OSC_NUM_CH,
    parameter int DATA_W      = `OSC_DATA_W,
    parameter int SEL_W       = `OSC_SEL_W,
    parameter int CONV_CYCLES = `OSC_CONV_CYCLES
) (
    // clock and reset
    input  wire logic                     clk,
    input  wire logic                     rst,
    // host conversion control
    input  wire logic                     convert_start_group_a,
    input  wire logic                     convert_start_group_b,
    input  wire logic [SEL_W-1:0]         ratio_select_pins,
    // converter core sample handshake
    output logic                          sample_req,
    input  wire logic                     sample_valid,
    input  wire logic [NUM_CH*DATA_W-1:0] sample_data,
    // status and results
    output logic                          busy,
    output logic [SEL_W-1:0]              oversampling_ratio,
    output logic [NUM_CH*DATA_W-1:0]      result_data
);
    // hazards and limits
    // - result_data and oversampling_ratio move only in the cycle busy falls,
    //   so a host read anywhere inside the busy period sees the previous set
    // - a start edge seen while busy is dropped, not queued
    // - codes above the largest ratio fall back to a single sample set
    // - sample_req stands until sample_valid is seen, then drops for the wait
    // - the wait after each sample set is fixed; a slow core only stretches busy

    localparam int CNT_W = $clog2(CONV_CYCLES + 1) + 1;
    localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CYCLES - 1);

    // start detection
    logic                     start;
    logic                     start_prev;
    logic                     next_start_prev;
    logic                     start_rise;
    // sequencer and counters
    osc_pkg::osc_state_t      state;
    osc_pkg::osc_state_t      next_state;
    logic [CNT_W-1:0]         cnt;
    logic [CNT_W-1:0]         next_cnt;
    logic [7:0]               left;
    logic [7:0]               next_left;
    logic                     next_req;
    logic                     wait_end;
    logic                     last_set;
    // averaging filter control
    logic [SEL_W-1:0]         eff_sel;
    logic                     acc_clear;
    logic                     acc_add;
    logic [NUM_CH*DATA_W-1:0] mean_all;
    // status and results
    logic                     finish;
    logic                     next_busy;
    logic [SEL_W-1:0]         next_ratio;
    logic [NUM_CH*DATA_W-1:0] next_result;

    // both start inputs must be high together
    assign start = convert_start_group_a & convert_start_group_b;
    // only an idle sequencer takes a fresh rising edge; held or repeated starts are ignored
    assign start_rise = start & ~start_prev & (state == osc_pkg::OSC_IDLE);
    // ratio codes above the largest valid one act as no oversampling
    assign eff_sel = (oversampling_ratio > `OSC_SEL_MAX_RATIO) ? `OSC_SEL_RESET : oversampling_ratio;
    // accumulators restart in idle
    assign acc_clear = (state == osc_pkg::OSC_IDLE);
    // sample set taken in the cycle the core shows it; the core need not hold it afterwards
    assign acc_add = (state == osc_pkg::OSC_REQ) & sample_valid;
    // end of the fixed wait after a sample set
    assign wait_end = (state == osc_pkg::OSC_WAIT) & (cnt == CONV_LAST);
    // the set just waited for was the last of this busy period
    assign last_set = (left == 8'h01);
    // last cycle of the busy period
    assign finish = (state == osc_pkg::OSC_DONE);

    // one averaging filter per channel
    // each keeps a running sum and shows the sum shifted by eff_sel as its mean
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            osc_avg #(
                .DATA_W (DATA_W),
                .SEL_W  (SEL_W)
            ) u_avg (
                .clk    (clk),
                .rst    (rst),
                .clear  (acc_clear),
                .add    (acc_add),
                .shift  (eff_sel),
                .sample (sample_data[g*DATA_W +: DATA_W]),
                .mean   (mean_all[g*DATA_W +: DATA_W])
            );
        end
    endgenerate

    // start edge detector next value
    always_comb begin
        next_start_prev = start;
    end

    // start edge detector register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            start_prev <= 1'b0;
        end else begin
            start_prev <= next_start_prev;
        end
    end

    // sequencer: N sample sets per busy period, each followed by a fixed wait
    always_comb begin
        next_state = state;
        next_req   = 1'b0;
        unique case (state)
            osc_pkg::OSC_IDLE: begin
                if (start_rise) begin
                    next_req   = 1'b1;
                    next_state = osc_pkg::OSC_REQ;
                end
            end
            osc_pkg::OSC_REQ: begin
                if (sample_valid) begin
                    next_state = osc_pkg::OSC_WAIT;
                end else begin
                    next_req = 1'b1; // request stands until answered
                end
            end
            osc_pkg::OSC_WAIT: begin
                if (wait_end) begin
                    if (last_set) begin
                        next_state = osc_pkg::OSC_DONE;
                    end else begin
                        next_req   = 1'b1;
                        next_state = osc_pkg::OSC_REQ;
                    end
                end
            end
            osc_pkg::OSC_DONE: begin
                next_state = osc_pkg::OSC_IDLE;
            end
        endcase
    end

    // sequencer registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state      <= osc_pkg::OSC_IDLE;
            sample_req <= 1'b0;
        end else begin
            state      <= next_state;
            sample_req <= next_req;
        end
    end

    // wait counter and sample sets still to take
    always_comb begin
        next_cnt  = cnt;
        next_left = left;
        if (start_rise) begin
            next_cnt  = '0;
            next_left = 8'(1 << eff_sel);
        end else if (state == osc_pkg::OSC_WAIT) begin
            if (wait_end) begin
                next_cnt  = '0;
                next_left = left - 8'h01;
            end else begin
                next_cnt = cnt + CNT_W'(1);
            end
        end
    end

    // counter registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt  <= '0;
            left <= 8'h00;
        end else begin
            cnt  <= next_cnt;
            left <= next_left;
        end
    end

    // busy, ratio and result next values
    always_comb begin
        next_busy   = busy;
        next_ratio  = oversampling_ratio;
        next_result = result_data;
        if (start_rise) begin
            next_busy = 1'b1;
        end
        if (finish) begin
            next_busy   = 1'b0;
            next_ratio  = ratio_select_pins;
            next_result = mean_all;
        end
    end

    // status registers; result and ratio stand still while busy
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy               <= 1'b0;
            oversampling_ratio <= `OSC_SEL_RESET;
            result_data        <= '0;
        end else begin
            busy               <= next_busy;
            oversampling_ratio <= next_ratio;
            result_data        <= next_result;
        end
    end
endmodule : osc_ctrl

// ### verif/osc_core_model.sv
// converter core stand-in answering sample requests
`timescale 1ns/1ps
module osc_core_model (
    // clock and reset
    input wire logic               clk,
    input wire logic               rst,
    // request and pacing
    input wire logic               sample_req,
    input wire logic [1:0]         lag,
    input wire logic signed [13:0] lvl,
    // sample set towards the block
    output logic                   sample_valid,
    output logic [111:0]           sample_data
);
    logic [1:0] w;
    logic par;
    // answer after lag cycles, spread flips sign each set
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            {sample_valid, w, par, sample_data} <= '0;
        end else if (sample_valid || !sample_req) begin
            {sample_valid, w} <= '0;
        end else if (w != lag) begin
            w <= w + 2'h1;
        end else begin
            {sample_valid, par} <= {1'b1, ~par};
            for (int g = 0; g < 8; g++) sample_data[g*14+:14] <= par ? lvl + 14'(g) : lvl - 14'(g);
        end
    end
endmodule : osc_core_model

// ### verif/osc_ctrl_properties.sv
// assertions for the oversampling conversion control
`timescale 1ns/1ps
module osc_ctrl_properties (
    // clock and reset
    input wire logic         clk,
    input wire logic         rst,
    // host pins
    input wire logic         convert_start_group_a,
    input wire logic         convert_start_group_b,
    input wire logic [2:0]   ratio_select_pins,
    // core handshake
    input wire logic         sample_req,
    input wire logic         sample_valid,
    // status and results
    input wire logic         busy,
    input wire logic [2:0]   oversampling_ratio,
    input wire logic [111:0] result_data
);
    logic [7:0] n;
    // sample sets taken in this busy period
    always_ff @(posedge clk or posedge rst) begin
        if (rst) n <= 8'h0;
        else n <= busy ? n + 8'(sample_req && sample_valid) : 8'h0;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    ratio_latch_a: assert property ($fell(busy) |-> oversampling_ratio == $past(ratio_select_pins))
        else $error("ratio latch");
    ratio_hold_a: assert property (busy |-> $stable(oversampling_ratio))
        else $error("ratio moved");
    result_hold_a: assert property (busy |-> $stable(result_data))
        else $error("result moved");
    start_busy_a: assert property (!busy && $rose(convert_start_group_a && convert_start_group_b) |=> busy)
        else $error("no busy");
    busy_run_a: assert property ($rose(busy) |-> busy [*8])
        else $error("busy short");
    set_count_a: assert property ($fell(busy) |-> n == 8'h1 << ($past(oversampling_ratio) % 3'h7))
        else $error("set count");
    req_hold_a: assert property (sample_req && !sample_valid |=> sample_req)
        else $error("request dropped");
    cover property ($fell(busy) && $past(oversampling_ratio) == 3'h6);
    cover property ($fell(busy) && $past(oversampling_ratio) == 3'h7);
    cover property ($rose(busy));
endmodule : osc_ctrl_properties
bind osc_ctrl osc_ctrl_properties i_osc_ctrl_properties (.*);

// ### verif/osc_ctrl_tb.sv
// bench for the oversampling conversion control
`timescale 1ns/1ps
module osc_ctrl_tb;
    logic clk = 1'b0, rst = 1'b1, st = 1'b0, par = 1'b0, req, vld, busy;
    logic [2:0] pins = 3'h0, cur = 3'h0, ratio;
    logic [1:0] lag = 2'h0;
    logic signed [13:0] lvl = 14'h0;
    logic [111:0] sd, res, prev = '0;
    int error_cnt = 0, cmp_count = 0, seed = 32'h0e17, t, s;
    always #25 clk = ~clk;
    osc_ctrl i_osc_ctrl (.clk, .rst, .convert_start_group_a(st), .convert_start_group_b(st),
        .ratio_select_pins(pins), .sample_req(req), .sample_valid(vld), .sample_data(sd), .busy,
        .oversampling_ratio(ratio), .result_data(res));
    osc_core_model i_osc_core_model (.clk, .rst, .sample_req(req), .lag, .lvl, .sample_valid(vld), .sample_data(sd));
    // a single sample keeps its spread, longer runs cancel it
    function automatic logic [111:0] mean_of(input logic one, input logic p, input logic signed [13:0] v);
        for (int g = 0; g < 8; g++) mean_of[g*14+:14] = one ? (p ? v + 14'(g) : v - 14'(g)) : v;
    endfunction : mean_of
    task automatic chk(input logic [111:0] got, input logic [111:0] want);
        cmp_count++;
        if (got !== want) begin
            error_cnt++;
            $display("mismatch at %0t: %h %h", $time, got, want);
        end
    endtask : chk
    task automatic close_out;
        $display("checks %0d errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : close_out
    // every code in turn, then random codes
    initial begin
        repeat (16) @(negedge clk);
        rst = 1'b0;
        for (int c = 0; c < 20; c++) begin
            s = (cur == 3'h7) ? 0 : cur;
            pins = (c < 9) ? 3'(c) : 3'($random(seed));
            lag = 2'($random(seed));
            lvl = 14'($random(seed) % 4096);
            st = 1'b1;
            repeat (2) @(negedge clk);
            chk(res, prev);
            // every other run, a fresh start edge inside busy must be ignored
            if (c % 2 == 1) begin
                st = 1'b0;
                @(negedge clk);
                st = 1'b1;
            end
            for (t = 0; busy === 1'b1 && t < 3000; t++) @(negedge clk);
            if (t == 3000) begin
                error_cnt++;
                close_out;
            end
            prev = mean_of(s == 0, par, lvl);
            chk(112'(ratio), 112'(pins));
            chk(res, prev);
            chk(112'(t >= (20 << s)), 112'h1);
            par ^= (s == 0);
            cur = pins;
            st = 1'b0;
            @(negedge clk);
        end
        close_out;
    end
endmodule : osc_ctrl_tb
